// ---- design/pcgs_top.sv ----
// press cycle guard sequencer with axi4-lite configuration slave
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pcgs_params.svh"
module pcgs_top #(
    parameter int TICK_CYC = `PCGS_TICK_NS / `PCGS_CLK_NS
) (
    input wire logic ref_clk, // 250 mhz system clock
    input wire logic reset_n, // async reset, active low
    input wire pcgs_pkg::pcgs_pins_s pin_i, // press and guard pins
    output logic enable_out, // press enable
    output logic breach_out, // guard breach flag
    output logic timeout_out, // supervision time exceeded
    output logic rearm_need_out, // rearm sequence pending
    output logic int_need_out, // interventions pending
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    import pcgs_pkg::*;

    // saturating millisecond increment
    function automatic logic [22:0] ms_inc(input logic [22:0] v);
        ms_inc = (v == 23'h7FFFFF) ? v : v + 23'h000001;
    endfunction

    logic [1:0] rst_q;
    logic rst_n;
    pcgs_pins_s s1_q, s2_q, s3_q;
    logic [17:0] tick_cnt_q;
    logic tick;
    logic [31:0] cfg0_q, cfg1_q;
    pcgs_cfg0_s cfg0;
    pcgs_cfg1_s cfg1;
    logic [22:0] glow_ms_q, rhigh_ms_q, mute_ms_q, seq_ms_q;
    logic [22:0] mute_lim, seq_lim, glow_min, rearm_min;
    pcgs_state_e st_q;
    logic enable_q, breach_q, timeout_q, mute_q, seq_q;
    logic rdone_q, orig_q, dcseen_q, fallok_q;
    logic pend_q, bad_q, free_q, freeused_q;
    logic [3:0] cnt_q;
    logic g_fall, g_rise, dc_rise, ru_rise, rr_fall;
    logic mute_en, mute_end, seq_exp, int_ok, rearm_ok;
    logic ints_done, rearm_done, rel2_ok, seq_done;
    logic rneed_d, ineed_d, rneed_q, ineed_q;
    logic wr_go;
    pcgs_stat_s stat;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // pins come from the press, so two flops before any use; reset to idle levels so no false guard edge follows
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= pcgs_pins_s'(`PCGS_PINS_IDLE);
            s2_q <= pcgs_pins_s'(`PCGS_PINS_IDLE);
            s3_q <= pcgs_pins_s'(`PCGS_PINS_IDLE);
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // synchronous edge detection on the second stage
    assign g_fall = !s2_q.guard && s3_q.guard;
    assign g_rise = s2_q.guard && !s3_q.guard;
    assign dc_rise = s2_q.dead_centre && !s3_q.dead_centre;
    assign ru_rise = s2_q.run_up && !s3_q.run_up;
    assign rr_fall = !s2_q.rearm && s3_q.rearm;

    // common millisecond tick for every timer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 18'h00001;
        end
    end
    assign tick = (tick_cnt_q == 18'(TICK_CYC - 1));

    // configuration view and derived limits
    assign cfg0 = pcgs_cfg0_s'(cfg0_q[24:0]);
    assign cfg1 = pcgs_cfg1_s'(cfg1_q[11:0]);
    assign mute_lim = 23'(cfg0.mute_s * `PCGS_MS_PER_S);
    assign seq_lim = 23'(cfg0.seq_s * `PCGS_MS_PER_S);
    assign glow_min = cfg1.guard_long ? `PCGS_LONG_MS : `PCGS_SHORT_MS;
    assign rearm_min = cfg1.rearm_long ? `PCGS_LONG_MS : `PCGS_SHORT_MS;

    // pulse width timers: guard low time and rearm high time
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            glow_ms_q <= '0;
            rhigh_ms_q <= '0;
        end else begin
            if (s2_q.guard) begin
                glow_ms_q <= '0;
            end else if (tick) begin
                glow_ms_q <= ms_inc(glow_ms_q);
            end
            if (!s2_q.rearm) begin
                rhigh_ms_q <= '0;
            end else if (tick) begin
                rhigh_ms_q <= ms_inc(rhigh_ms_q);
            end
        end
    end

    // glow_ms_q still holds the low time on the rising-edge cycle
    assign int_ok = g_rise && fallok_q && dcseen_q && (glow_ms_q >= glow_min);
    assign rearm_ok = rr_fall && (rhigh_ms_q >= rearm_min) && (rhigh_ms_q <= `PCGS_REARM_MAX_MS);
    assign mute_en = (cfg0.mute_s != 13'h0000);
    assign mute_end = mute_q && ((mute_ms_q >= mute_lim) || !s2_q.run_up || s2_q.dead_centre);
    assign seq_exp = seq_q && (seq_lim != 23'h000000) && (seq_ms_q >= seq_lim);

    // completion terms of a start sequence
    assign ints_done = (cnt_q >= cfg1.n_int);
    assign rearm_done = (cfg1.lock == `PCGS_LOCK_NONE) || rdone_q;
    assign rel2_ok = (st_q == ST_LOCKED) ?
        ((cfg1.rel2 != `PCGS_REL2_EVERY && cfg1.rel2 != `PCGS_REL2_FIRST) || s2_q.secondary_en) :
        ((cfg1.rel2 != `PCGS_REL2_EVERY) || s2_q.secondary_en);
    assign seq_done = ints_done && rel2_ok && ((st_q == ST_CYCLE) || rearm_done);

    // main sequencer; only the run state may hold enable high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_LOCKED;
            enable_q <= 1'b0;
            breach_q <= 1'b0;
            timeout_q <= 1'b0;
            mute_q <= 1'b0;
            mute_ms_q <= '0;
            seq_q <= 1'b0;
            seq_ms_q <= '0;
            rdone_q <= 1'b0;
            cnt_q <= '0;
            orig_q <= 1'b0;
            dcseen_q <= 1'b0;
            fallok_q <= 1'b0;
            pend_q <= 1'b0;
            bad_q <= 1'b0;
            free_q <= 1'b0;
            freeused_q <= 1'b0;
        end else begin
            // qualifying edges for the first intervention
            if (dc_rise) begin
                dcseen_q <= 1'b1;
            end
            if ((cfg1.origin_runup && ru_rise) || (!cfg1.origin_runup && dc_rise)) begin
                orig_q <= 1'b1;
            end
            if (g_fall) begin
                fallok_q <= orig_q || (cfg1.origin_runup ? ru_rise : dc_rise);
            end
            // bypass timer, regranted on every run-up rise
            if (ru_rise && mute_en) begin
                mute_q <= 1'b1;
                mute_ms_q <= '0;
            end else if (mute_end) begin
                mute_q <= 1'b0;
            end else if (mute_q && tick) begin
                mute_ms_q <= ms_inc(mute_ms_q);
            end
            // supervision timer runs only while a sequence is awaited
            if (seq_q && tick) begin
                seq_ms_q <= ms_inc(seq_ms_q);
            end
            case (st_q)
                ST_RUN: begin
                    if (dc_rise) begin
                        // end of stroke: stop, and start supervising the next start
                        enable_q <= 1'b0;
                        cnt_q <= '0;
                        seq_q <= 1'b1;
                        seq_ms_q <= '0;
                        free_q <= 1'b0;
                        freeused_q <= 1'b0;
                        pend_q <= 1'b0;
                        if (bad_q) begin
                            breach_q <= 1'b1;
                            st_q <= ST_LOCKED;
                            rdone_q <= 1'b0;
                        end else begin
                            st_q <= ST_CYCLE;
                        end
                    end else if (mute_end && !s2_q.guard) begin
                        enable_q <= 1'b0;
                        breach_q <= 1'b1;
                        if (cfg1.lock == `PCGS_LOCK_DOWN) begin
                            st_q <= ST_HOLD;
                        end else if (cfg1.lock == `PCGS_LOCK_ALWAYS) begin
                            st_q <= ST_LOCKED;
                            rdone_q <= 1'b0;
                            cnt_q <= '0;
                        end else begin
                            st_q <= ST_CYCLE;
                            cnt_q <= '0;
                        end
                    end else if (mute_q) begin
                        // muted: guard ignored, policy 2 remembers the intervention
                        if (mute_end && cfg1.lock == `PCGS_LOCK_DOWN) begin
                            free_q <= 1'b1;
                        end
                        if (g_fall && cfg1.lock == `PCGS_LOCK_ALWAYS) begin
                            if (cfg1.origin_runup) begin
                                pend_q <= 1'b1;
                            end else begin
                                bad_q <= 1'b1;
                            end
                        end
                        if (g_rise && pend_q && !dcseen_q) begin
                            bad_q <= 1'b1;
                            pend_q <= 1'b0;
                        end
                    end else begin
                        if (g_rise && free_q) begin
                            freeused_q <= 1'b1;
                        end
                        if (g_rise && pend_q && !dcseen_q) begin
                            bad_q <= 1'b1;
                            pend_q <= 1'b0;
                        end
                        if (g_fall && !(free_q && !freeused_q) && !pend_q) begin
                            enable_q <= 1'b0;
                            breach_q <= 1'b1;
                            cnt_q <= '0;
                            rdone_q <= 1'b0;
                            if (cfg1.lock == `PCGS_LOCK_NONE) begin
                                st_q <= ST_CYCLE;
                            end else begin
                                st_q <= ST_LOCKED;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    // intervention ended: restore without any lock
                    if (g_rise) begin
                        enable_q <= 1'b1;
                        st_q <= ST_RUN;
                    end
                end
                default: begin
                    // locked or cycle: wait for the start sequence
                    if (seq_exp) begin
                        timeout_q <= 1'b1;
                        st_q <= ST_LOCKED;
                        seq_q <= 1'b0;
                        cnt_q <= '0;
                        rdone_q <= 1'b0;
                    end else if (seq_done) begin
                        enable_q <= 1'b1;
                        st_q <= ST_RUN;
                        breach_q <= 1'b0;
                        timeout_q <= 1'b0;
                        seq_q <= 1'b0;
                        rdone_q <= 1'b0;
                        cnt_q <= '0;
                        orig_q <= 1'b0;
                        dcseen_q <= 1'b0;
                        fallok_q <= 1'b0;
                        bad_q <= 1'b0;
                    end else begin
                        if (int_ok && (st_q == ST_CYCLE || !cfg1.rearm_first || rearm_done)) begin
                            if (cnt_q != 4'hF) begin
                                cnt_q <= cnt_q + 4'h1;
                            end
                            if (!seq_q && !cfg1.rearm_first) begin
                                seq_q <= 1'b1;
                                seq_ms_q <= '0;
                            end
                        end
                        if (rearm_ok && st_q == ST_LOCKED && cfg1.lock != `PCGS_LOCK_NONE &&
                            (cfg1.rearm_first || ints_done)) begin
                            rdone_q <= 1'b1;
                            if (!seq_q && cfg1.rearm_first) begin
                                seq_q <= 1'b1;
                                seq_ms_q <= '0;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // pending-part flags: first part first, then the second
    always_comb begin
        rneed_d = 1'b0;
        ineed_d = 1'b0;
        if (st_q == ST_CYCLE) begin
            ineed_d = !ints_done;
        end else if (st_q == ST_LOCKED) begin
            if (cfg1.lock == `PCGS_LOCK_NONE) begin
                ineed_d = !ints_done;
            end else if (cfg1.rearm_first) begin
                rneed_d = !rdone_q;
                ineed_d = rdone_q && !ints_done;
            end else begin
                ineed_d = !ints_done;
                rneed_d = ints_done && !rdone_q;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rneed_q <= 1'b0;
            ineed_q <= 1'b0;
        end else begin
            rneed_q <= rneed_d;
            ineed_q <= ineed_d;
        end
    end
    // outputs straight from flops
    assign enable_out = enable_q;
    assign breach_out = breach_q;
    assign timeout_out = timeout_q;
    assign rearm_need_out = rneed_q;
    assign int_need_out = ineed_q;
    // status view of the sequencer, packed in field order
    assign stat = pcgs_stat_s'({mute_q, (st_q == ST_LOCKED), cnt_q, ineed_q, rneed_q, timeout_q, breach_q, enable_q});
    // write path takes address and data together, one write at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg0_q <= `PCGS_CFG0_RST;
            cfg1_q <= `PCGS_CFG1_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCGS_RESP_OKAY;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `PCGS_RESP_OKAY;
                for (int i = 0; i < 4; i++) begin
                    if (s_axi_wstrb[i] && s_axi_awaddr == `PCGS_CFG0_ADDR) begin
                        cfg0_q[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
                    end
                    if (s_axi_wstrb[i] && s_axi_awaddr == `PCGS_CFG1_ADDR) begin
                        cfg1_q[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
                    end
                end
                if (s_axi_awaddr != `PCGS_CFG0_ADDR && s_axi_awaddr != `PCGS_CFG1_ADDR) begin
                    s_axi_bresp <= `PCGS_RESP_SLVERR; // status is read only
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path answers one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `PCGS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PCGS_RESP_OKAY;
                case (s_axi_araddr)
                    `PCGS_CFG0_ADDR: s_axi_rdata <= {7'h00, cfg0_q[24:16], 3'h0, cfg0_q[12:0]};
                    `PCGS_CFG1_ADDR: s_axi_rdata <= {20'h00000, cfg1_q[11:0]};
                    `PCGS_STAT_ADDR: s_axi_rdata <= {21'h000000, stat};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= `PCGS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ---- design/pcgs_params.svh ----
// constants for the press cycle guard sequencer
`ifndef PCGS_PARAMS_SVH
`define PCGS_PARAMS_SVH
`define PCGS_CLK_NS 4
`define PCGS_TICK_NS 1000000
`define PCGS_MS_PER_S 23'h0003E8
`define PCGS_SHORT_MS 23'h000064
`define PCGS_LONG_MS 23'h00015E
`define PCGS_REARM_MAX_MS 23'h007530
`define PCGS_CFG0_ADDR 4'h0
`define PCGS_CFG1_ADDR 4'h4
`define PCGS_STAT_ADDR 4'h8
`define PCGS_CFG0_RST 32'h001E0000
`define PCGS_CFG1_RST 32'h00000051
`define PCGS_PINS_IDLE 5'h10
`define PCGS_LOCK_NONE 2'h1
`define PCGS_LOCK_ALWAYS 2'h2
`define PCGS_LOCK_DOWN 2'h3
`define PCGS_REL2_EVERY 2'h2
`define PCGS_REL2_FIRST 2'h3
`define PCGS_RESP_OKAY 2'h0
`define PCGS_RESP_SLVERR 2'h2
`endif

// ---- design/pcgs_pkg.sv ----
// types shared by the press cycle guard sequencer
package pcgs_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_CYCLE = 2'b01,
        ST_RUN = 2'b10,
        ST_HOLD = 2'b11
    } pcgs_state_e;
    // press-side input pins
    typedef struct packed {
        logic guard;
        logic dead_centre;
        logic run_up;
        logic rearm;
        logic secondary_en;
    } pcgs_pins_s;
    // configuration word 0, low bits of the register
    typedef struct packed {
        logic [8:0] seq_s;
        logic [2:0] pad;
        logic [12:0] mute_s;
    } pcgs_cfg0_s;
    // configuration word 1, low bits of the register
    typedef struct packed {
        logic guard_long;
        logic rearm_long;
        logic [3:0] n_int;
        logic rearm_first;
        logic [1:0] lock;
        logic origin_runup;
        logic [1:0] rel2;
    } pcgs_cfg1_s;
    // status word, low bits of the register
    typedef struct packed {
        logic muting;
        logic locked;
        logic [3:0] count;
        logic int_need;
        logic rearm_need;
        logic timeout;
        logic breach;
        logic enable;
    } pcgs_stat_s;
endpackage

// ---- tb/pcgs_assertions.sv ----
// port-level checks of the sequencer and its configuration slave
`timescale 1ns/1ps
module pcgs_assertions (
    input wire logic ref_clk, // clock
    input wire logic reset_n, // reset, active low
    input wire logic enable_out, // press enable
    input wire logic breach_out, // breach flag
    input wire logic timeout_out, // timeout flag
    input wire logic rearm_need_out, // rearm pending
    input wire logic int_need_out, // interventions pending
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [31:0] s_axi_rdata // read data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // a request is taken only while no answer is pending
    sequence wr_taken; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
    sequence rd_taken; s_axi_arvalid && !s_axi_rvalid; endsequence
    AST_WR_READY: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
        && s_axi_wready == s_axi_awready) else $error("write ready wrong");
    AST_RD_READY: assert property (s_axi_arready == !s_axi_rvalid) else $error("read ready wrong");
    AST_WR_ANSWER: assert property (wr_taken |=> s_axi_bvalid) else $error("write answer late");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_BREACH_OFF: assert property ($rose(breach_out) |-> !enable_out) else $error("breach with enable");
    AST_TIMEOUT_OFF: assert property ($rose(timeout_out) |-> !enable_out) else $error("timeout with enable");
    AST_ENABLE_DONE: assert property ($rose(enable_out) |-> ##[0:2] !rearm_need_out && !int_need_out)
        else $error("enable with parts pending");
endmodule
bind pcgs_top pcgs_assertions u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .enable_out(enable_out),
    .breach_out(breach_out), .timeout_out(timeout_out), .rearm_need_out(rearm_need_out),
    .int_need_out(int_need_out), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata));

// ---- tb/pcgs_press_model.sv ----
// press and light-curtain model driving the sequencer pins
`timescale 1ns/1ps
module pcgs_press_model (
    input wire logic ref_clk, // system clock
    output pcgs_pkg::pcgs_pins_s pins_o // press side pins
);
    import pcgs_pkg::*;
    logic [4:0] pin_q = 5'h11; // curtain clear, secondary enable high
    assign pins_o = pin_q;
    // invert one pin for a span, then restore; guard low then high is one intervention
    task pulse(input int idx, input int cyc);
        @(posedge ref_clk);
        pin_q[idx] <= ~pin_q[idx];
        repeat (cyc) @(posedge ref_clk);
        pin_q[idx] <= ~pin_q[idx];
    endtask
endmodule

// ---- tb/pcgs_tb_top.sv ----
// self-checking bench for the press cycle guard sequencer
`timescale 1ns/1ps
module pcgs_tb_top;
    import pcgs_pkg::*;
    localparam int TICK = 10; // one millisecond in cycles, shortened for speed
    localparam int MS100 = 100 * TICK;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    pcgs_pins_s pins;
    logic enable_out, breach_out, timeout_out, rearm_need_out, int_need_out;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, s_rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [15:0] seed = 16'h0027;
    int error_cnt = 0;
    int total_checks = 0;
    // clock at 250 mhz
    initial forever #2 ref_clk = ~ref_clk;
    pcgs_press_model u_pcgs_press_model (.ref_clk(ref_clk), .pins_o(pins));
    pcgs_top #(.TICK_CYC(TICK)) u_pcgs_top (.ref_clk(ref_clk), .reset_n(reset_n), .pin_i(pins),
        .enable_out(enable_out), .breach_out(breach_out), .timeout_out(timeout_out),
        .rearm_need_out(rearm_need_out), .int_need_out(int_need_out), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(s_rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ready is looked at before the edge, so the edge itself is the handshake
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do @(negedge ref_clk); while (!awready);
        @(posedge ref_clk);
        {awvalid, wvalid} <= 2'h0;
        do @(negedge ref_clk); while (!bvalid);
        chk(bresp, er);
        @(posedge ref_clk);
        bready <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(negedge ref_clk); while (!arready);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        do @(negedge ref_clk); while (!rvalid);
        chk(s_rdata & m, exp);
        chk(rresp, er);
        @(posedge ref_clk);
        rready <= 1'b0;
    endtask
    // complete start in standard order with one intervention
    task start_seq();
        u_pcgs_press_model.pulse(3, 20);
        repeat (8) @(posedge ref_clk);
        chk(int_need_out, 1'b1);
        seed = lfsr(seed);
        u_pcgs_press_model.pulse(4, MS100 + 20 + seed[7:0]);
        repeat (8) @(posedge ref_clk);
        chk({int_need_out, rearm_need_out}, 2'h1);
        u_pcgs_press_model.pulse(1, MS100 + 20);
        repeat (8) @(posedge ref_clk);
        chk({enable_out, rearm_need_out, breach_out}, 3'h4);
    endtask
    task tally_and_finish();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(4'h0, 32'h01FF1FFF, 32'h001E0000, 2'h0);
        rd_chk(4'h4, 32'h00000FFF, 32'h00000051, 2'h0);
        rd_chk(4'h8, 32'h00000007, 32'h0, 2'h0);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0, 2'h2);
        wr(4'h8, 32'h1, 2'h2);
        repeat (4) begin
            seed = lfsr(seed);
            wr(4'h0, {seed, ~seed}, 2'h0);
            rd_chk(4'h0, 32'h01FF1FFF, {seed, ~seed} & 32'h01FF1FFF, 2'h0);
        end
        // muting and supervision off, default run-up origin unused so muting needs no pairing
        wr(4'h0, 32'h0, 2'h0);
        start_seq();
        u_pcgs_press_model.pulse(4, MS100 + 20);
        repeat (8) @(posedge ref_clk);
        chk({enable_out, breach_out}, 2'h1);
        rd_chk(4'h8, 32'h00000200, 32'h00000200, 2'h0);
        u_pcgs_press_model.pulse(3, 20);
        u_pcgs_press_model.pulse(4, MS100 - 50);
        repeat (8) @(posedge ref_clk);
        rd_chk(4'h8, 32'h000001E0, 32'h0, 2'h0);
        start_seq();
        wr(4'h0, 32'h00010000, 2'h0);
        u_pcgs_press_model.pulse(3, 20);
        repeat (1000 * TICK + 100) @(posedge ref_clk);
        chk({enable_out, timeout_out}, 2'h1);
        // policy 3 with muting: guard clear when run-up falls and muting ends grants one free intervention, the next one locks
        wr(4'h4, 32'h00000059, 2'h0);
        wr(4'h0, 32'h00000001, 2'h0);
        start_seq();
        u_pcgs_press_model.pulse(2, 20);
        repeat (8) @(posedge ref_clk);
        u_pcgs_press_model.pulse(4, 30);
        repeat (8) @(posedge ref_clk);
        chk(enable_out, 1'b1);
        u_pcgs_press_model.pulse(4, 30);
        repeat (8) @(posedge ref_clk);
        chk({enable_out, breach_out}, 2'h1);
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({enable_out, timeout_out, breach_out}, 3'h0);
        rd_chk(4'h4, 32'h00000FFF, 32'h00000051, 2'h0);
        tally_and_finish();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
